/* logic/adc_mode_defs.vh */
// Mode codes, timing counts and sizes for the converter mode control
`ifndef ADC_MODE_DEFS_VH
`define ADC_MODE_DEFS_VH

`define MODE_W          4
`define MODE_RESET      4'h0
`define MODE_CONT       4'h0
`define MODE_SINGLE     4'h4
`define MODE_STANDBY    4'h5
`define MODE_PWRDN      4'h6
`define MODE_IDLE       4'h7
`define MODE_SYS_ZERO   4'h8
`define MODE_SYS_FULL   4'h9
`define MODE_INT_ZERO   4'hA

`define NUM_CH          4
`define CH_W            2
`define DATA_W          24

`define WAKE_ONES       63
`define WAKE_REPEATS    3
`define WAKE_CNT_W      6
`define WAKE_REP_W      2

`define CMD_STREAM_OFF  2'h0
`define CMD_STREAM_RD   2'h1
`define CMD_STREAM_TX   2'h2

`endif

/* logic/wake_pattern_detect.v */
// Detector for the serial-interface reset pattern
`timescale 1ns/100ps
`default_nettype none
`include "adc_mode_defs.vh"

module wake_pattern_detect (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Serial bit stream
  input  wire bitValid,
  input  wire bitData,
  // Detection
  output reg  wakeHit
);

  reg [`WAKE_CNT_W-1:0] onesCnt_q;
  reg [`WAKE_REP_W-1:0] repCnt_q;

  // ----------------------------------------
  // Pattern counter
  // ----------------------------------------
  // count ones then zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      onesCnt_q <= {`WAKE_CNT_W{1'b0}};
      repCnt_q  <= {`WAKE_REP_W{1'b0}};
      wakeHit   <= 1'b0;
    end else begin
      wakeHit <= 1'b0;
      if (bitValid) begin
        if (bitData) begin
          if (onesCnt_q != `WAKE_CNT_W'd`WAKE_ONES) begin
            onesCnt_q <= onesCnt_q + `WAKE_CNT_W'd1;
          end else begin
            onesCnt_q <= {`WAKE_CNT_W{1'b0}};
            repCnt_q  <= {`WAKE_REP_W{1'b0}};
          end
        end else begin
          onesCnt_q <= {`WAKE_CNT_W{1'b0}};
          if (onesCnt_q == `WAKE_CNT_W'd`WAKE_ONES) begin
            if (repCnt_q == `WAKE_REP_W'd`WAKE_REPEATS - `WAKE_REP_W'd1) begin
              repCnt_q <= {`WAKE_REP_W{1'b0}};
              wakeHit  <= 1'b1;
            end else begin
              repCnt_q <= repCnt_q + `WAKE_REP_W'd1;
            end
          end else begin
            repCnt_q <= {`WAKE_REP_W{1'b0}};
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

/* logic/adc_operating_mode_control.v */
// Operating-mode sequencer for a sigma-delta converter
`timescale 1ns/100ps
`default_nettype none
`include "adc_mode_defs.vh"

module adc_operating_mode_control (
  // Clock and reset
  input  wire                   clk_sys,
  input  wire                   rst,
  // Mode write from the serial interface
  input  wire                   modeWrite,
  input  wire [`MODE_W-1:0]     modeData,
  input  wire [1:0]             streamSelIn,
  input  wire                   streamWrite,
  // Channel enables and keep-alive settings
  input  wire [`NUM_CH-1:0]     chanEnable,
  input  wire [3:0]             keepAlive,
  // Modulator and filter result path
  input  wire                   convDone,
  input  wire [`DATA_W-1:0]     convResult,
  // Serial bit stream for wake detection (asynchronous pins)
  input  wire                   serBitValid,
  input  wire                   serBitData,
  // Status and control outputs
  output reg  [`MODE_W-1:0]     mode_q,
  output reg  [1:0]             streamingReadoutSelect,
  output reg                    readyN,
  output reg  [`DATA_W-1:0]     dataReg,
  output reg                    convRun,
  output reg                    filterHold,
  output reg                    modClkOn,
  output reg                    inputShort,
  output reg  [3:0]             analogKeepOn,
  output reg                    ldoOn,
  output reg                    regLoss,
  output reg                    coefWrite,
  output reg                    coefIsGain,
  output reg  [`CH_W-1:0]       coefChannel,
  output reg  [`DATA_W-1:0]     coefValue
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [1:0] bitValidSync;
  reg [1:0] bitDataSync;
  reg       bitValidOld_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitValidSync  <= 2'h0;
      bitDataSync   <= 2'h0;
      bitValidOld_q <= 1'b0;
    end else begin
      bitValidSync  <= {bitValidSync[0], serBitValid};
      bitDataSync   <= {bitDataSync[0], serBitData};
      bitValidOld_q <= bitValidSync[1];
    end
  end

  wire bitStrobe = bitValidSync[1] & ~bitValidOld_q;
  wire wakeHit;

  // ----------------------------------------
  // Wake pattern detection
  // ----------------------------------------
  wake_pattern_detect wakeDet (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .bitValid (bitStrobe),
    .bitData  (bitDataSync[1]),
    .wakeHit  (wakeHit)
  );

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function isLegal;
    input [`MODE_W-1:0] m;
    begin
      case (m)
        `MODE_CONT, `MODE_SINGLE, `MODE_STANDBY, `MODE_PWRDN, `MODE_IDLE,
        `MODE_SYS_ZERO, `MODE_SYS_FULL, `MODE_INT_ZERO: isLegal = 1'b1;
        default: isLegal = 1'b0;
      endcase
    end
  endfunction

  function isCal;
    input [`MODE_W-1:0] m;
    begin
      isCal = (m == `MODE_SYS_ZERO) || (m == `MODE_SYS_FULL) || (m == `MODE_INT_ZERO);
    end
  endfunction

  function isPowerOff;
    input [`MODE_W-1:0] m;
    begin
      isPowerOff = (m == `MODE_STANDBY) || (m == `MODE_PWRDN);
    end
  endfunction

  function [`CH_W-1:0] firstChan;
    input [`NUM_CH-1:0] en;
    integer i;
    begin
      firstChan = {`CH_W{1'b0}};
      // Lowest enabled channel wins
      for (i = `NUM_CH - 1; i >= 0; i = i - 1) begin
        if (en[i]) begin
          firstChan = i[`CH_W-1:0];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  localparam ST_RUN   = 2'h0;
  localparam ST_CAL   = 2'h1;
  localparam ST_WAIT  = 2'h2;
  localparam ST_DOWN  = 2'h3;

  reg [1:0]         state_q;
  reg [`NUM_CH-1:0] pending_q;

  wire [`CH_W-1:0]  curChan = firstChan(pending_q);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q                <= ST_RUN;
      mode_q                 <= `MODE_RESET;
      streamingReadoutSelect <= `CMD_STREAM_OFF;
      readyN                 <= 1'b1;
      dataReg                <= {`DATA_W{1'b0}};
      pending_q              <= {`NUM_CH{1'b0}};
      coefWrite              <= 1'b0;
      coefIsGain             <= 1'b0;
      coefChannel            <= {`CH_W{1'b0}};
      coefValue              <= {`DATA_W{1'b0}};
      regLoss                <= 1'b0;
    end else begin
      // One-cycle strobes
      coefWrite <= 1'b0;
      regLoss   <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (modeWrite && isLegal(modeData)) begin
            if (modeData == `MODE_PWRDN && mode_q != `MODE_STANDBY) begin
              mode_q <= mode_q;
            end else begin
              mode_q <= modeData;
              if (modeData != `MODE_CONT) begin
                streamingReadoutSelect <= `CMD_STREAM_OFF;
              end
              if (modeData == `MODE_SINGLE) begin
                pending_q <= chanEnable;
              end
              if (isCal(modeData)) begin
                readyN    <= 1'b1;
                pending_q <= chanEnable;
                state_q   <= ST_CAL;
              end
              if (modeData == `MODE_PWRDN) begin
                state_q <= ST_DOWN;
              end
            end
          end else if (streamWrite) begin
            if (mode_q == `MODE_CONT || streamSelIn == `CMD_STREAM_OFF) begin
              streamingReadoutSelect <= streamSelIn;
            end
          end else if (convDone) begin
            if (mode_q == `MODE_CONT) begin
              dataReg <= convResult;
              readyN  <= 1'b0;
            end
            if (mode_q == `MODE_SINGLE) begin
              dataReg <= convResult;
              readyN  <= 1'b0;
              pending_q[curChan] <= 1'b0;
              if ((pending_q & ~(`NUM_CH'd1 << curChan)) == {`NUM_CH{1'b0}}) begin
                mode_q <= `MODE_STANDBY;
              end
            end
          end
        end
        ST_CAL: begin
          if (convDone) begin
            coefWrite   <= 1'b1;
            coefChannel <= firstChan(pending_q);
            coefValue   <= convResult;
            coefIsGain  <= (mode_q == `MODE_SYS_FULL);
            state_q     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          readyN  <= 1'b0;
          mode_q  <= `MODE_IDLE;
          state_q <= ST_RUN;
        end
        ST_DOWN: begin
          if (wakeHit) begin
            regLoss                <= 1'b1;
            mode_q                 <= `MODE_RESET;
            streamingReadoutSelect <= `CMD_STREAM_OFF;
            dataReg                <= {`DATA_W{1'b0}};
            readyN                 <= 1'b1;
            pending_q              <= {`NUM_CH{1'b0}};
            coefIsGain             <= 1'b0;
            coefChannel            <= {`CH_W{1'b0}};
            coefValue              <= {`DATA_W{1'b0}};
            state_q                <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Analog and clock control
  // ----------------------------------------
  reg       convRun_d;
  reg       filterHold_d;
  reg       modClkOn_d;
  reg       inputShort_d;
  reg [3:0] analogKeepOn_d;
  reg       ldoOn_d;

  always @* begin
    convRun_d    = (mode_q == `MODE_CONT) || (mode_q == `MODE_SINGLE) ||
                   (state_q == ST_CAL);
    filterHold_d = (mode_q == `MODE_IDLE) || isPowerOff(mode_q);
    modClkOn_d   = !isPowerOff(mode_q);
    inputShort_d = (mode_q == `MODE_INT_ZERO);
    if (mode_q == `MODE_STANDBY) begin
      analogKeepOn_d = keepAlive;
    end else if (mode_q == `MODE_PWRDN) begin
      analogKeepOn_d = 4'h0;
    end else begin
      analogKeepOn_d = 4'hF;
    end
    ldoOn_d      = (mode_q != `MODE_PWRDN);
  end

  // Controls leave from flip-flops
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      convRun      <= 1'b0;
      filterHold   <= 1'b1;
      modClkOn     <= 1'b0;
      inputShort   <= 1'b0;
      analogKeepOn <= 4'h0;
      ldoOn        <= 1'b1;
    end else begin
      convRun      <= convRun_d;
      filterHold   <= filterHold_d;
      modClkOn     <= modClkOn_d;
      inputShort   <= inputShort_d;
      analogKeepOn <= analogKeepOn_d;
      ldoOn        <= ldoOn_d;
    end
  end

endmodule

`default_nettype wire

/* dv/adc_mode_assertions.sv */
// Checker for the mode sequencer outputs
`timescale 1ns/100ps
`default_nettype none
module adc_mode_assertions (
  // Clock, reset and inputs
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        modeWrite,
  input wire logic [3:0]  modeData,
  input wire logic        streamWrite,
  input wire logic        convDone,
  input wire logic [23:0] convResult,
  input wire logic [3:0]  keepAlive,
  // Outputs
  input wire logic [3:0]  mode_q,
  input wire logic [1:0]  streamingReadoutSelect,
  input wire logic        readyN,
  input wire logic [23:0] dataReg,
  input wire logic        filterHold,
  input wire logic        modClkOn,
  input wire logic        inputShort,
  input wire logic [3:0]  analogKeepOn,
  input wire logic        ldoOn,
  input wire logic        regLoss,
  input wire logic        coefWrite,
  input wire logic        coefIsGain,
  input wire logic [23:0] coefValue
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_CAL_START: assert property (modeWrite && modeData == 4'h8 && mode_q == 4'h7
    |=> readyN && mode_q == 4'h8) else $error("cal start wrong");
  AST_CAL_END: assert property (mode_q[3] && convDone && !modeWrite && !streamWrite
    |=> coefWrite ##1 mode_q == 4'h7 && !readyN) else $error("cal end wrong");
  AST_COEF_KIND: assert property (coefWrite |-> coefIsGain == (mode_q == 4'h9))
    else $error("coef kind wrong");
  AST_COEF_VAL: assert property (coefWrite |-> coefValue == $past(convResult))
    else $error("coef value wrong");
  AST_CONV: assert property (mode_q == 4'h0 && convDone && !modeWrite && !streamWrite
    |=> !readyN && dataReg == $past(convResult)) else $error("conversion wrong");
  AST_IDLE: assert property (mode_q == 4'h7 [*2] |-> filterHold && modClkOn)
    else $error("idle wrong");
  AST_SHORT: assert property (mode_q == 4'hA [*2] |-> inputShort)
    else $error("short wrong");
  AST_PWRDN: assert property (mode_q == 4'h6 [*2] |-> !ldoOn && analogKeepOn == 4'h0)
    else $error("power-down wrong");
  AST_STANDBY: assert property (mode_q == 4'h5 [*2]
    |-> ldoOn && analogKeepOn == $past(keepAlive)) else $error("standby wrong");
  AST_STREAM: assert property (mode_q != 4'h0 [*3] |-> streamingReadoutSelect == 2'h0)
    else $error("stream select wrong");
  AST_WAKE: assert property (regLoss |=> !regLoss && mode_q == 4'h0)
    else $error("wake wrong");
  cover property (coefWrite && coefIsGain);
  cover property (regLoss);
  cover property (mode_q == 4'h5 && $past(mode_q) == 4'h4);
endmodule
bind adc_operating_mode_control adc_mode_assertions chk (.clk_sys, .rst, .modeWrite, .modeData,
  .streamWrite, .convDone, .convResult, .keepAlive, .mode_q, .streamingReadoutSelect, .readyN,
  .dataReg, .filterHold, .modClkOn, .inputShort, .analogKeepOn, .ldoOn, .regLoss, .coefWrite,
  .coefIsGain, .coefValue);
`default_nettype wire

/* dv/host_serial_model.sv */
// Host model sending the serial wake pattern
`timescale 1ns/100ps
`default_nettype none
module host_serial_model (
  // Clock and request
  input  wire logic clk_sys,
  input  wire logic sendWake,
  // Serial pins
  output var logic  serBitValid,
  output var logic  serBitData,
  output var logic  busy
);
  integer rep;
  integer b;
  initial begin
    serBitValid = 1'b0;
    serBitData  = 1'b0;
    busy        = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (sendWake) begin
        busy <= 1'b1;
        for (rep = 0; rep < 3; rep++)
          for (b = 0; b < 64; b++) begin
            serBitData <= (b < 63);
            repeat (3) @(posedge clk_sys);
            serBitValid <= 1'b1;
            repeat (3) @(posedge clk_sys);
            serBitValid <= 1'b0;
          end
        busy <= 1'b0;
      end else begin
        serBitData <= ~serBitData;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the mode sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  // Stimulus
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        modeWrite = 1'b0;
  logic [3:0]  modeData = 4'h0;
  logic [1:0]  streamSelIn = 2'h0;
  logic        streamWrite = 1'b0;
  logic [3:0]  chanEnable = 4'h1;
  logic [3:0]  keepAlive = 4'h0;
  logic        convDone = 1'b0;
  logic [23:0] convResult = 24'h000000;
  logic        sendWake = 1'b0;
  // Observed
  logic        serBitValid, serBitData, busy, readyN, convRun, filterHold, modClkOn;
  logic        inputShort, ldoOn, regLoss, coefWrite, coefIsGain;
  logic [3:0]  mode_q, analogKeepOn;
  logic [1:0]  streamingReadoutSelect, coefChannel;
  logic [23:0] dataReg, coefValue;
  integer      miscompares = 0;
  integer      cmp_count = 0;
  adc_operating_mode_control dut (.clk_sys, .rst, .modeWrite, .modeData, .streamSelIn,
    .streamWrite, .chanEnable, .keepAlive, .convDone, .convResult, .serBitValid, .serBitData,
    .mode_q, .streamingReadoutSelect, .readyN, .dataReg, .convRun, .filterHold, .modClkOn,
    .inputShort, .analogKeepOn, .ldoOn, .regLoss, .coefWrite, .coefIsGain, .coefChannel,
    .coefValue);
  host_serial_model host (.clk_sys, .sendWake, .serBitValid, .serBitData, .busy);
  always #25 clk_sys = ~clk_sys;
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wrMode(input logic [3:0] c);
    @(posedge clk_sys);
    modeWrite <= 1'b1;
    modeData  <= c;
    @(posedge clk_sys);
    modeWrite <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic conv(input logic [23:0] v);
    @(posedge clk_sys);
    convDone   <= 1'b1;
    convResult <= v;
    @(posedge clk_sys);
    convDone <= 1'b0;
    #1;
  endtask
  task automatic runCont;
    `CHK(mode_q, 4'h0)
    `CHK(convRun, 1'b1)
    conv(24'hA5C3F1);
    `CHK(dataReg, 24'hA5C3F1)
    `CHK(readyN, 1'b0)
    @(posedge clk_sys);
    streamWrite <= 1'b1;
    streamSelIn <= 2'h2;
    @(posedge clk_sys);
    streamWrite <= 1'b0;
    #1;
    `CHK(streamingReadoutSelect, 2'h2)
  endtask
  task automatic runIdle;
    wrMode(4'h7);
    `CHK(filterHold, 1'b1)
    `CHK(modClkOn, 1'b1)
    `CHK(convRun, 1'b0)
    `CHK(streamingReadoutSelect, 2'h0)
  endtask
  task automatic runCal(input logic [3:0] c, input logic [23:0] v);
    integer i;
    wrMode(c);
    `CHK(readyN, 1'b1)
    `CHK(inputShort, c == 4'hA)
    conv(v);
    for (i = 0; i < 20 && coefWrite !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(coefWrite, 1'b1)
    if (coefWrite !== 1'b1) give_verdict;
    `CHK(coefIsGain, c == 4'h9)
    `CHK(coefChannel, 2'h2)
    `CHK(coefValue, v)
    @(posedge clk_sys);
    #1;
    `CHK(mode_q, 4'h7)
    `CHK(readyN, 1'b0)
  endtask
  task automatic runPwrdn;
    integer i;
    wrMode(4'h6);
    `CHK(mode_q, 4'h7)
    wrMode(4'h5);
    wrMode(4'h6);
    `CHK(ldoOn, 1'b0)
    `CHK(analogKeepOn, 4'h0)
    `CHK(modClkOn, 1'b0)
    @(posedge clk_sys);
    sendWake <= 1'b1;
    @(posedge clk_sys);
    sendWake <= 1'b0;
    for (i = 0; i < 3000 && regLoss !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(regLoss, 1'b1)
    if (regLoss !== 1'b1) give_verdict;
    `CHK(busy, 1'b0)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(mode_q, 4'h0)
    `CHK(dataReg, 24'h000000)
  endtask
  task automatic runSingle;
    @(posedge clk_sys);
    chanEnable <= 4'h3;
    keepAlive  <= 4'hA;
    wrMode(4'h4);
    conv(24'h000111);
    @(posedge clk_sys);
    #1;
    `CHK(mode_q, 4'h4)
    conv(24'h000222);
    @(posedge clk_sys);
    #1;
    `CHK(mode_q, 4'h5)
    @(posedge clk_sys);
    #1;
    `CHK(analogKeepOn, 4'hA)
    `CHK(ldoOn, 1'b1)
    `CHK(dataReg, 24'h000222)
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(readyN, 1'b1)
    runCont;
    runIdle;
    @(posedge clk_sys);
    chanEnable <= 4'h4;
    runCal(4'h8, 24'h012345);
    runCal(4'h9, 24'hFEDCBA);
    runCal(4'hA, 24'h00000F);
    runPwrdn;
    runSingle;
    give_verdict;
  end
endmodule
`default_nettype wire
